/* hdl/sync_serial.sv */
// Purpose: clock synchronous serial channel with an AHB-Lite slave
// Assumes: link_clk is the level of the transfer clock actually in use
// Notes:   mode/polarity/order change only while the channel is idle
//
// Implementation choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "css_consts.svh"
module sync_serial #(
    parameter int W         = 8,
    parameter int HALF_CYC  = `CSS_HALF_DEF
) (
    // system
    input  wire logic        clk,
    input  wire logic        reset,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // link clock domain
    input  wire logic        link_clk,
    // serial data pins
    output logic             serial_out_pin_o,
    output logic             serial_out_pin_oe,
    input  wire logic        serial_in_pin,
    // clock pins
    output logic             transfer_clock_pin_o,
    output logic             transfer_clock_pin_oe,
    output logic             alt_clock_pin_o,
    output logic             alt_clock_pin_oe,
    // flow control pin
    input  wire logic        flow_control_pin_i,
    output logic             flow_control_pin_o,
    output logic             flow_control_pin_oe
);
    localparam int CW = $clog2(W);
    localparam logic [CW-1:0] LAST = CW'(W - 1);
    localparam logic [5:0] EDGES = 6'(2 * W);
    localparam logic [7:0] HALF = 8'(HALF_CYC - 1);

    css_pkg::mode_cfg_t    cfg;
    css_pkg::frame_state_t state_reg;
    css_pkg::frame_state_t state_next;
    css_pkg::pin_drv_t     flow_drv;

    logic [7:0]    mode_reg;
    logic [7:0]    ctl_reg;
    logic [7:0]    sel_reg;
    logic [1:0]    gpio_reg;
    logic [W-1:0]  txbuf_reg;
    logic [W-1:0]  txword_reg;
    logic [W-1:0]  rxbuf_reg;
    logic          tx_full_reg;
    logic          rx_full_reg;
    logic          ovr_reg;
    logic          arm_reg;
    logic          started_reg;
    logic          start_tgl_reg;
    logic [7:0]    half_reg;
    logic [5:0]    edges_reg;
    logic          sclk_reg;
    logic          done1_reg;
    logic          done2_reg;
    logic          done3_reg;
    logic          cts1_reg;
    logic          cts2_reg;
    logic          rxp1_reg;
    logic          rxp2_reg;
    logic          wr_pend_reg;
    logic [7:0]    wa_reg;
    logic [31:0]   hrdata_reg;
    logic [31:0]   rd_mux;
    // link domain
    logic          seen_reg     = 1'b0;
    logic [CW-1:0] cnt_reg      = '0;
    logic [W-1:0]  rxsh_reg;
    logic [W-1:0]  rxword_reg;
    logic [W-1:0]  rx_next;
    logic          done_tgl_reg = 1'b0;
    logic          tx_bit_reg   = 1'b1;

    // configuration fields
    assign cfg.en   = mode_reg[`CSS_B_EN];
    assign cfg.od   = mode_reg[`CSS_B_OD];
    assign cfg.fsel = mode_reg[`CSS_B_FSEL];
    assign cfg.ext  = mode_reg[`CSS_B_EXT];
    assign cfg.fdis = mode_reg[`CSS_B_FDIS];
    assign cfg.pol  = mode_reg[`CSS_B_POL];
    assign cfg.msb  = mode_reg[`CSS_B_MSB];

    wire te    = ctl_reg[`CSS_B_TE];
    wire re    = ctl_reg[`CSS_B_RE];
    wire cont  = ctl_reg[`CSS_B_CONT];
    wire inv   = ctl_reg[`CSS_B_INV];
    wire alt_act = sel_reg[`CSS_B_ALT] & ~cfg.ext;
    wire pick  = sel_reg[`CSS_B_PICK];

    // ahb-lite address phase and decode
    wire ap    = hsel & hready & htrans[1];
    wire rd_ap = ap & ~hwrite;
    wire [7:0] a_ap = haddr[7:0];
    wire rd_rx = rd_ap & (a_ap == `CSS_OFF_RX);
    wire wr_mode = wr_pend_reg & (wa_reg == `CSS_OFF_MODE);
    wire wr_ctl  = wr_pend_reg & (wa_reg == `CSS_OFF_CTL);
    wire wr_sel  = wr_pend_reg & (wa_reg == `CSS_OFF_SEL);
    wire wr_tx   = wr_pend_reg & (wa_reg == `CSS_OFF_TX);
    wire wr_stat = wr_pend_reg & (wa_reg == `CSS_OFF_STAT);
    wire wr_gpio = wr_pend_reg & (wa_reg == `CSS_OFF_GPIO);

    // flow control selection
    wire flow_on  = cfg.en & ~cfg.fdis & ~alt_act;
    wire cts_mode = flow_on & ~cfg.fsel;
    wire rts_mode = flow_on & cfg.fsel;
    wire cts_ok   = ~cts_mode | ~cts2_reg;

    // frame start and completion
    wire busy  = (state_reg != css_pkg::FR_IDLE);
    wire go    = cfg.en & te & (tx_full_reg | arm_reg) & cts_ok;
    wire load  = (state_reg == css_pkg::FR_IDLE) & go;
    wire done  = done2_reg ^ done3_reg;
    wire half_end = (half_reg == HALF);

    // read mux
    always_comb begin
        rd_mux = `CSS_RST32;
        if (a_ap == `CSS_OFF_MODE) begin
            rd_mux[7:0] = mode_reg;
        end else if (a_ap == `CSS_OFF_CTL) begin
            rd_mux[7:0] = ctl_reg;
        end else if (a_ap == `CSS_OFF_SEL) begin
            rd_mux[7:0] = sel_reg;
        end else if (a_ap == `CSS_OFF_RX) begin
            rd_mux[W-1:0] = inv ? ~rxbuf_reg : rxbuf_reg;
        end else if (a_ap == `CSS_OFF_STAT) begin
            rd_mux[`CSS_B_TXE]   = ~tx_full_reg;
            rd_mux[`CSS_B_RXF]   = rx_full_reg;
            rd_mux[`CSS_B_OVR]   = ovr_reg;
            rd_mux[`CSS_B_BUSY]  = busy;
            rd_mux[`CSS_B_RXPIN] = rxp2_reg;
            rd_mux[`CSS_B_FLPIN] = cts2_reg;
        end else if (a_ap == `CSS_OFF_GPIO) begin
            rd_mux[1:0] = gpio_reg;
        end
    end

    // bus slave registers
    always_ff @(posedge clk) begin
        if (reset) begin
            wr_pend_reg <= 1'b0;
            wa_reg      <= `CSS_RST8;
            hrdata_reg  <= `CSS_RST32;
        end else begin
            wr_pend_reg <= ap & hwrite;
            wa_reg      <= a_ap;
            if (rd_ap) begin
                hrdata_reg <= rd_mux;
            end
        end
    end

    assign hrdata    = hrdata_reg;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // configuration registers
    always_ff @(posedge clk) begin
        if (reset) begin
            mode_reg <= `CSS_RST8;
            ctl_reg  <= `CSS_RST8;
            sel_reg  <= `CSS_RST8;
            gpio_reg <= 2'h0;
        end else begin
            if (wr_mode) begin
                mode_reg <= hwdata[7:0];
            end
            if (wr_ctl) begin
                ctl_reg <= hwdata[7:0];
            end
            if (wr_sel) begin
                sel_reg <= hwdata[7:0];
            end
            if (wr_gpio) begin
                gpio_reg <= hwdata[1:0];
            end
        end
    end

    // transmit buffer
    always_ff @(posedge clk) begin
        if (reset) begin
            txbuf_reg   <= '0;
            tx_full_reg <= 1'b0;
        end else begin
            if (wr_tx) begin
                txbuf_reg <= inv ? ~hwdata[W-1:0]
                                 : hwdata[W-1:0];
            end
            tx_full_reg <= wr_tx | (tx_full_reg & ~load);
        end
    end

    // continuous receive re-arm on buffer read
    always_ff @(posedge clk) begin
        if (reset) begin
            arm_reg <= 1'b0;
        end else begin
            arm_reg <= (rd_rx & cont & re)
                     | (arm_reg & ~load & cont);
        end
    end

    // receive buffer and overrun
    always_ff @(posedge clk) begin
        if (reset) begin
            rxbuf_reg   <= '0;
            rx_full_reg <= 1'b0;
            ovr_reg     <= 1'b0;
        end else begin
            if (done & re) begin
                rxbuf_reg <= rxword_reg;
            end
            rx_full_reg <= (done & re)
                         | (rx_full_reg & ~rd_rx);
            ovr_reg <= (done & re & rx_full_reg & ~rd_rx)
                     | (ovr_reg
                        & ~(wr_stat & hwdata[`CSS_B_OVR]));
        end
    end

    // frame state machine
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            css_pkg::FR_IDLE: begin
                if (go) begin
                    state_next = cfg.ext ? css_pkg::FR_WAIT
                                         : css_pkg::FR_CLOCK;
                end
            end
            css_pkg::FR_CLOCK: begin
                if (half_end && edges_reg == 6'h01) begin
                    state_next = css_pkg::FR_WAIT;
                end
            end
            css_pkg::FR_WAIT: begin
                if (done) begin
                    state_next = css_pkg::FR_IDLE;
                end
            end
            default: begin
                state_next = css_pkg::FR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= css_pkg::FR_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // frame word capture and start toggle
    always_ff @(posedge clk) begin
        if (reset) begin
            txword_reg    <= '0;
            start_tgl_reg <= 1'b0;
            started_reg   <= 1'b0;
        end else begin
            if (load) begin
                txword_reg    <= txbuf_reg;
                start_tgl_reg <= ~start_tgl_reg;
            end
            started_reg <= cfg.en & (started_reg | load);
        end
    end

    // internal transfer clock divider
    always_ff @(posedge clk) begin
        if (reset) begin
            half_reg  <= 8'h00;
            edges_reg <= 6'h00;
            sclk_reg  <= 1'b1;
        end else if (state_reg == css_pkg::FR_CLOCK) begin
            half_reg <= half_end ? 8'h00 : half_reg + 8'h01;
            if (half_end) begin
                sclk_reg  <= ~sclk_reg;
                edges_reg <= edges_reg - 6'h01;
            end
        end else begin
            half_reg  <= 8'h00;
            edges_reg <= EDGES;
            sclk_reg  <= ~cfg.pol;
        end
    end

    // synchronisers into clk domain
    always_ff @(posedge clk) begin
        if (reset) begin
            done1_reg <= 1'b0;
            done2_reg <= 1'b0;
            done3_reg <= 1'b0;
            cts1_reg  <= 1'b1;
            cts2_reg  <= 1'b1;
            rxp1_reg  <= 1'b1;
            rxp2_reg  <= 1'b1;
        end else begin
            done1_reg <= done_tgl_reg;
            done2_reg <= done1_reg;
            done3_reg <= done2_reg;
            cts1_reg  <= flow_control_pin_i;
            cts2_reg  <= cts1_reg;
            rxp1_reg  <= serial_in_pin;
            rxp2_reg  <= rxp1_reg;
        end
    end

    // link domain: sample on one edge, shift out on the other
    wire edge_clk = link_clk ^ cfg.pol;
    wire new_frame = (start_tgl_reg != seen_reg);
    wire [CW-1:0] bit_idx = new_frame ? '0 : cnt_reg;
    wire [CW-1:0] pos = cfg.msb ? (LAST - bit_idx)
                                : bit_idx;

    always_comb begin
        rx_next = rxsh_reg;
        rx_next[pos] = serial_in_pin;
    end

    always_ff @(posedge edge_clk) begin
        seen_reg <= start_tgl_reg;
        rxsh_reg <= rx_next;
        if (bit_idx == LAST) begin
            cnt_reg      <= '0;
            rxword_reg   <= rx_next;
            done_tgl_reg <= ~done_tgl_reg;
        end else begin
            cnt_reg <= bit_idx + CW'(1);
        end
    end

    always_ff @(negedge edge_clk) begin
        tx_bit_reg <= txword_reg[pos];
    end

    // serial data output
    wire out_lvl = started_reg ? tx_bit_reg : 1'b1;
    assign serial_out_pin_o  = cfg.od ? 1'b0 : out_lvl;
    assign serial_out_pin_oe = cfg.en
                             & (~cfg.od | ~out_lvl);

    // transfer clock pins
    assign transfer_clock_pin_o  = sclk_reg;
    assign transfer_clock_pin_oe = cfg.en & ~cfg.ext
                                 & ~(alt_act & pick);
    assign alt_clock_pin_o  = sclk_reg;
    assign alt_clock_pin_oe = cfg.en & alt_act & pick;

    // flow control pin
    always_comb begin
        flow_drv.o  = 1'b1;
        flow_drv.oe = 1'b0;
        if (rts_mode) begin
            flow_drv.o  = ~(re & ~rx_full_reg);
            flow_drv.oe = 1'b1;
        end else if (cfg.fdis) begin
            flow_drv.o  = gpio_reg[`CSS_B_GOUT];
            flow_drv.oe = gpio_reg[`CSS_B_GOE];
        end
    end

    assign flow_control_pin_o  = flow_drv.o;
    assign flow_control_pin_oe = flow_drv.oe;

endmodule : sync_serial

/* hdl/css_consts.svh */
// Purpose: offsets, bit positions and reset values of the serial channel
// Assumes: byte addresses on haddr[7:0]
// Notes:   definitions only
`ifndef CSS_CONSTS_SVH
`define CSS_CONSTS_SVH
// register byte offsets
`define CSS_OFF_MODE   8'h00
`define CSS_OFF_CTL    8'h04
`define CSS_OFF_SEL    8'h08
`define CSS_OFF_TX     8'h0C
`define CSS_OFF_RX     8'h10
`define CSS_OFF_STAT   8'h14
`define CSS_OFF_GPIO   8'h18
// mode register bits
`define CSS_B_EN       0
`define CSS_B_OD       1
`define CSS_B_FSEL     2
`define CSS_B_EXT      3
`define CSS_B_FDIS     4
`define CSS_B_POL      6
`define CSS_B_MSB      7
// control register bits
`define CSS_B_TE       0
`define CSS_B_RE       2
`define CSS_B_CONT     5
`define CSS_B_INV      6
// clock pin select register bits
`define CSS_B_ALT      4
`define CSS_B_PICK     5
// status register bits
`define CSS_B_TXE      0
`define CSS_B_RXF      1
`define CSS_B_OVR      2
`define CSS_B_BUSY     3
`define CSS_B_RXPIN    4
`define CSS_B_FLPIN    5
// gpio register bits
`define CSS_B_GOUT     0
`define CSS_B_GOE      1
// reset values and counts
`define CSS_RST8       8'h00
`define CSS_RST32      32'h0000_0000
`define CSS_HALF_DEF   4
`endif

/* hdl/css_pkg.sv */
// Purpose: types shared by the serial channel
// Assumes: constants come from css_consts.svh
// Notes:   no imports; use css_pkg::name
package css_pkg;
    typedef struct packed {
        logic o;
        logic oe;
    } pin_drv_t;
    typedef struct packed {
        logic msb;
        logic pol;
        logic fdis;
        logic ext;
        logic fsel;
        logic od;
        logic en;
    } mode_cfg_t;
    typedef enum logic [1:0] {
        FR_IDLE,
        FR_CLOCK,
        FR_WAIT
    } frame_state_t;
endpackage : css_pkg

/* tb/sync_serial_chk.sv */
// Purpose: port-level checks of the serial channel
// Assumes: register map of css_consts.svh
// Notes:   shadows the config registers from bus writes
`timescale 1ns/1ps
`include "css_consts.svh"
module sync_serial_chk #(
    parameter int W        = 8,
    parameter int HALF_CYC = `CSS_HALF_DEF
) (
    // system
    input wire logic        clk,
    input wire logic        reset,
    // bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // link and pins
    input wire logic        link_clk,
    input wire logic        serial_out_pin_o,
    input wire logic        serial_out_pin_oe,
    input wire logic        serial_in_pin,
    input wire logic        transfer_clock_pin_o,
    input wire logic        transfer_clock_pin_oe,
    input wire logic        alt_clock_pin_o,
    input wire logic        alt_clock_pin_oe,
    input wire logic        flow_control_pin_i,
    input wire logic        flow_control_pin_o,
    input wire logic        flow_control_pin_oe
);
    logic [7:0] shadow_reg [8];
    logic [2:0] wa_reg;
    logic       wr_reg;
    logic       seen_reg;
    logic       tq_reg;
    logic [5:0] tog_reg;
    logic [5:0] idle_reg;
    wire        en    = shadow_reg[0][`CSS_B_EN];
    wire        od    = shadow_reg[0][`CSS_B_OD];
    wire        fsel  = shadow_reg[0][`CSS_B_FSEL];
    wire        ext   = shadow_reg[0][`CSS_B_EXT];
    wire        fdis  = shadow_reg[0][`CSS_B_FDIS];
    wire        goe   = shadow_reg[6][`CSS_B_GOE];
    wire        gout  = shadow_reg[6][`CSS_B_GOUT];
    wire        mpin  = shadow_reg[2][`CSS_B_ALT] & ~ext;
    wire        route = mpin & shadow_reg[2][`CSS_B_PICK];
    // shadow of written registers, first-activity flag
    always_ff @(posedge clk) begin
        if (reset) begin
            shadow_reg <= '{default: 8'h00};
            wr_reg     <= 1'b0;
            seen_reg   <= 1'b0;
        end else begin
            wr_reg   <= hsel & hready & htrans[1] & hwrite;
            if (wr_reg) shadow_reg[wa_reg] <= hwdata[7:0];
            seen_reg <= seen_reg | (transfer_clock_pin_o != tq_reg)
                      | (wr_reg & wa_reg == 3'd3);
        end
        wa_reg <= haddr[4:2];
        tq_reg <= transfer_clock_pin_o;
    end
    // clock toggles per burst
    always_ff @(posedge clk) begin
        if (reset) begin
            tog_reg  <= '0;
            idle_reg <= '0;
        end else if (transfer_clock_pin_o != tq_reg) begin
            tog_reg  <= tog_reg + 6'd1;
            idle_reg <= '0;
        end else if (idle_reg == 6'(HALF_CYC + 1)) begin
            tog_reg <= '0;
        end else begin
            idle_reg <= idle_reg + 6'd1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    property p_idle_high;
        en && !od && !ext && !seen_reg
        |-> serial_out_pin_oe && serial_out_pin_o;
    endproperty
    a_idle_high: assert property (p_idle_high)
        else $error("data out not high before first frame");
    property p_idle_float;
        en && od && !seen_reg |-> !serial_out_pin_oe;
    endproperty
    a_idle_float: assert property (p_idle_float)
        else $error("open drain data out driven while idle");
    property p_clk_dir;
        en |-> transfer_clock_pin_oe == (!ext && !route);
    endproperty
    a_clk_dir: assert property (p_clk_dir)
        else $error("clock pin direction wrong");
    property p_flow_fn;
        en && !fdis && !mpin |-> flow_control_pin_oe == fsel;
    endproperty
    a_flow_fn: assert property (p_flow_fn)
        else $error("flow pin function wrong");
    property p_flow_gpio;
        en && fdis
        |-> flow_control_pin_oe == goe && (!goe || flow_control_pin_o == gout);
    endproperty
    a_flow_gpio: assert property (p_flow_gpio)
        else $error("flow pin not released as port");
    property p_alt_pin;
        en |-> alt_clock_pin_oe == route;
    endproperty
    a_alt_pin: assert property (p_alt_pin)
        else $error("alternate clock pin wrong");
    property p_route_flow;
        en && mpin && !fdis |-> !flow_control_pin_oe;
    endproperty
    a_route_flow: assert property (p_route_flow)
        else $error("flow pin active with routed clock");
    property p_burst;
        idle_reg == 6'(HALF_CYC + 1) |-> tog_reg < 6'd2 || tog_reg == 6'd16;
    endproperty
    a_burst: assert property (p_burst)
        else $error("clock burst not sixteen edges");
endmodule : sync_serial_chk

bind sync_serial sync_serial_chk #(.W(W), .HALF_CYC(HALF_CYC)) chk (
    .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .link_clk(link_clk),
    .serial_out_pin_o(serial_out_pin_o),
    .serial_out_pin_oe(serial_out_pin_oe),
    .serial_in_pin(serial_in_pin),
    .transfer_clock_pin_o(transfer_clock_pin_o),
    .transfer_clock_pin_oe(transfer_clock_pin_oe),
    .alt_clock_pin_o(alt_clock_pin_o), .alt_clock_pin_oe(alt_clock_pin_oe),
    .flow_control_pin_i(flow_control_pin_i),
    .flow_control_pin_o(flow_control_pin_o),
    .flow_control_pin_oe(flow_control_pin_oe));

/* tb/link_peer.sv */
// Purpose: clocked serial peripheral at the far end of the link
// Assumes: sck is the level of the transfer clock in use
// Notes:   arm loads the reply byte before each frame
`timescale 1ns/1ps
module link_peer (
    // link
    input  wire logic sck,
    input  wire logic pol,
    input  wire logic msb,
    input  wire logic sdo,
    output logic      sdi
);
    logic [7:0] tx_reg;
    logic [7:0] rx_reg;
    int         n = 8;
    initial sdi = 1'b1;
    task automatic arm(input logic [7:0] b);
        tx_reg = b;
        n = 0;
    endtask : arm
    // drive on the change edge, sample on the other; idle line toggles
    always @(sck) begin
        if (sck === pol)
            sdi <= (n < 8) ? tx_reg[msb ? 7 - n : n] : ~sdi;
        else if (n < 8) begin
            rx_reg[msb ? 7 - n : n] <= sdo;
            n <= n + 1;
        end
    end
endmodule : link_peer

/* tb/sync_serial_test.sv */
// Purpose: self-checking bench of the serial channel
// Assumes: register map of css_consts.svh, HALF_CYC of 2
// Notes:   link clock follows the clock pin in use
`timescale 1ns/1ps
`include "css_consts.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module sync_serial_test;
    logic        clk     = 1'b0;
    logic        reset   = 1'b1;
    logic        hsel    = 1'b0;
    logic [31:0] haddr   = '0;
    logic [1:0]  htrans  = '0;
    logic        hwrite  = 1'b0;
    logic [31:0] hwdata  = '0;
    logic        eclk    = 1'b1;
    logic        ext_sel = 1'b0;
    logic        pol     = 1'b0;
    logic        msb     = 1'b0;
    logic        cts_n   = 1'b0;
    logic [2:0]  hsize   = 3'b010;
    int          n_fail  = 0;
    int          checks  = 0;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, sdo_o, sdo_oe, sdi, tck, tck_oe;
    wire         ack, ack_oe, fo, fo_oe;
    wire         sdo      = sdo_oe ? sdo_o : 1'b1;
    wire         link_clk = ext_sel ? eclk : (ack_oe ? ack : tck);
    always #12.5 clk = ~clk;
    sync_serial #(.HALF_CYC(2)) dut (
        .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .link_clk(link_clk), .serial_out_pin_o(sdo_o),
        .serial_out_pin_oe(sdo_oe), .serial_in_pin(sdi),
        .transfer_clock_pin_o(tck), .transfer_clock_pin_oe(tck_oe),
        .alt_clock_pin_o(ack), .alt_clock_pin_oe(ack_oe),
        .flow_control_pin_i(cts_n), .flow_control_pin_o(fo),
        .flow_control_pin_oe(fo_oe));
    link_peer peer (.sck(link_clk), .pol(pol), .msb(msb), .sdo(sdo),
                    .sdi(sdi));
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d, output logic [31:0] q);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= {24'h00_0000, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, d};
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [7:0] e, string n);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        `CHK(n, {24'h00_0000, e}, q)
    endtask : rd
    task automatic poll(input logic [7:0] m);
        logic [31:0] q;
        q = '0;
        for (int i = 0; i < 200 && (q[7:0] & m) == 8'h00; i++)
            bus(1'b0, `CSS_OFF_STAT, 8'h00, q);
        `CHK("status wait", 1'b1, |(q[7:0] & m))
    endtask : poll
    task automatic t_reset();
        `CHK("bus answer", 2'b10, {hreadyout, hresp})
        `CHK("pins off", 4'h0, {sdo_oe, tck_oe, ack_oe, fo_oe})
        rd(`CSS_OFF_MODE, 8'h00, "mode");
        rd(`CSS_OFF_SEL, 8'h00, "sel");
        rd(8'h1C, 8'h00, "unmapped");
    endtask : t_reset
    task automatic t_idle();
        logic [31:0] q;
        bus(1'b1, `CSS_OFF_MODE, 8'h01, q);
        repeat (2) @(posedge clk);
        `CHK("out idle", 2'b11, {sdo_oe, sdo_o})
        bus(1'b1, `CSS_OFF_MODE, 8'h03, q);
        repeat (2) @(posedge clk);
        `CHK("od idle", 1'b0, sdo_oe)
        bus(1'b0, `CSS_OFF_STAT, 8'h00, q);
        `CHK("in pin", sdi, q[`CSS_B_RXPIN])
    endtask : t_idle
    task automatic t_frames();
        logic [7:0]  mode [6] = '{8'h01, 8'h41, 8'h81, 8'hC1, 8'h01, 8'h09};
        logic [7:0]  ctl [6]  = '{8'h05, 8'h05, 8'h05, 8'h05, 8'h45, 8'h05};
        logic [31:0] q;
        logic [7:0]  tx;
        logic [7:0]  pb;
        logic        inv;
        for (int i = 0; i < 6; i++) begin
            tx = 8'h1E + i[7:0];
            pb = 8'hC5 - i[7:0];
            inv = ctl[i][`CSS_B_INV];
            ext_sel <= mode[i][`CSS_B_EXT];
            pol <= mode[i][`CSS_B_POL];
            msb <= mode[i][`CSS_B_MSB];
            bus(1'b1, `CSS_OFF_MODE, mode[i], q);
            bus(1'b1, `CSS_OFF_CTL, ctl[i], q);
            peer.arm(pb);
            bus(1'b1, `CSS_OFF_TX, tx, q);
            if (ext_sel) begin
                repeat (2) @(posedge clk);
                repeat (16) #16 eclk = ~eclk;
            end
            poll(8'h02);
            `CHK("wire byte", inv ? ~tx : tx, peer.rx_reg)
            bus(1'b0, `CSS_OFF_RX, 8'h00, q);
            `CHK("rx byte", {24'h00_0000, inv ? ~pb : pb}, q)
        end
        ext_sel <= 1'b0;
    endtask : t_frames
    task automatic t_cont();
        logic [31:0] q;
        bus(1'b1, `CSS_OFF_MODE, 8'h01, q);
        bus(1'b1, `CSS_OFF_CTL, 8'h25, q);
        peer.arm(8'h3C);
        bus(1'b1, `CSS_OFF_TX, 8'hA5, q);
        poll(8'h02);
        peer.arm(8'h6B);
        bus(1'b1, `CSS_OFF_TX, 8'h5A, q);
        poll(8'h04);
        peer.arm(8'h81);
        bus(1'b0, `CSS_OFF_RX, 8'h00, q);
        `CHK("overrun data", 32'h0000_006B, q)
        bus(1'b1, `CSS_OFF_STAT, 8'h04, q);
        poll(8'h02);
        bus(1'b1, `CSS_OFF_CTL, 8'h05, q);
        rd(`CSS_OFF_RX, 8'h81, "rearmed data");
        bus(1'b0, `CSS_OFF_STAT, 8'h00, q);
        `CHK("overrun clear", 1'b0, q[`CSS_B_OVR])
    endtask : t_cont
    task automatic t_cts();
        logic [31:0] q;
        cts_n <= 1'b1;
        bus(1'b1, `CSS_OFF_MODE, 8'h01, q);
        bus(1'b1, `CSS_OFF_TX, 8'h69, q);
        repeat (8) @(posedge clk);
        bus(1'b0, `CSS_OFF_STAT, 8'h00, q);
        `CHK("cts stall", 5'h10, {q[5], q[3:0]})
        peer.arm(8'h96);
        cts_n <= 1'b0;
        poll(8'h02);
        `CHK("cts byte", 8'h69, peer.rx_reg)
        rd(`CSS_OFF_RX, 8'h96, "cts rx");
    endtask : t_cts
    task automatic t_pins();
        logic [7:0]  mode [6] = '{8'h01, 8'h05, 8'h15, 8'h05, 8'h05, 8'h0D};
        logic [7:0]  sel [6]  = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h30, 8'h30};
        logic [3:0]  exp [6]  = '{4'h8, 4'hA, 4'hB, 4'h8, 4'h4, 4'h2};
        logic [31:0] q;
        bus(1'b1, `CSS_OFF_GPIO, 8'h03, q);
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, `CSS_OFF_MODE, mode[i], q);
            // the clock is routed only with ALT and PICK both set and EXT clear
            bus(1'b1, `CSS_OFF_SEL, sel[i], q);
            repeat (2) @(posedge clk);
            `CHK("pin use", exp[i], {tck_oe, ack_oe, fo_oe, fo & fo_oe})
            `CHK("alt level", i == 4, ack & ack_oe)
        end
    endtask : t_pins
    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_idle();
        t_frames();
        t_cont();
        t_cts();
        t_pins();
        report_and_stop();
    end
    initial begin
        #500_000;
        n_fail++;
        report_and_stop();
    end
endmodule : sync_serial_test
